// [pkg/brf_regs.svh]
/*
 Register offsets, field positions and reset values of the banked
 register file. Assumes byte addresses on a register port with an 8-bit address.
*/
`ifndef BRF_REGS_SVH
`define BRF_REGS_SVH
// ****************
// Register offsets
// ****************
`define BRF_CFG_OFS 8'h00
`define BRF_CSW_OFS 8'h04
`define BRF_SSW_OFS 8'h08
`define BRF_PC_OFS 8'h0C
// ****************
// Fields
// ****************
`define BRF_CFG_BIGEND 0
`define BRF_CFG_PROG 1
`define BRF_CFG_DATA 2
`define BRF_MODE_HI 4
`define BRF_LEGACY_BIT 4
`define BRF_AWIDE_LO 26
// ****************
// Reset values
// ****************
`define BRF_CFG_RST 3'h0
`define BRF_CSW_RST 32'h00000013
`define BRF_LEG_RST 32'h00000003
`endif

// [pkg/brf_pkg.sv]
/*
 Types of the banked register file: mode codes and register counts.
 Assumes nothing of its surroundings.
*/
package brf_pkg;
   typedef enum logic [4:0] {
      BRF_USR = 5'h10,
      BRF_FIQ = 5'h11,
      BRF_IRQ = 5'h12,
      BRF_SVC = 5'h13,
      BRF_ABT = 5'h17,
      BRF_UND = 5'h1B
   } brf_mode_t;
   typedef logic [4:0] brf_idx_t;
   localparam int BRF_NGP = 30;
   localparam int BRF_NSAVED = 5;
endpackage

// [verilog/brf_core.sv]
/*
 Banked register file with byte-order and address-space configuration.
 Assumes a datapath that drives one register access per cycle and a
 memory system on a 32-bit data bus; software config via a plain port.
*/
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "brf_regs.svh"
module brf_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [3:0] rf_raddr,
   output logic [31:0] rf_rdata,
   input wire logic rf_we,
   input wire logic [3:0] rf_waddr,
   input wire logic [31:0] rf_wdata,
   input wire logic exc_req,
   input wire logic [4:0] exc_mode,
   input wire logic [31:0] exc_link,
   input wire logic mem_req,
   input wire logic mem_fetch,
   input wire logic [31:0] mem_vaddr,
   input wire logic st_byte,
   input wire logic [31:0] st_data,
   input wire logic ld_byte,
   input wire logic [31:0] mem_rdata,
   output logic [28:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_lanes,
   output logic [31:0] ld_data,
   output logic addr_exc,
   output logic [4:0] mode_out,
   output logic priv_out
);
   // ****************
   // Helpers
   // ****************
   // Physical slot of a visible register: 0-14 shared, 15-21 fast bank,
   // 22-29 stack/link pairs of the other privileged modes
   function automatic brf_pkg::brf_idx_t bank_idx(input logic [4:0] m,
                                                  input logic [3:0] r);
      brf_pkg::brf_idx_t ix;
      ix = {1'b0, r};
      if (m[3:0] == 4'h1 && r >= 4'h8)
         ix = 5'd15 + {1'b0, r} - 5'd8;
      else if (r >= 4'hD) begin
         unique case (m[3:0])
            4'h3: ix = 5'd22 + {4'h0, r[1]};
            4'h7: ix = 5'd24 + {4'h0, r[1]};
            4'h2: ix = 5'd26 + {4'h0, r[1]};
            4'hB: ix = 5'd28 + {4'h0, r[1]};
            default: ix = {1'b0, r};
         endcase
      end
      return ix;
   endfunction

   function automatic logic [2:0] saved_idx(input logic [4:0] m);
      unique case (m[3:0])
         4'h1: return 3'h0;
         4'h3: return 3'h1;
         4'h7: return 3'h2;
         4'h2: return 3'h3;
         default: return 3'h4;
      endcase
   endfunction

   // Maps a requested code to what the configuration allows; top bit set when allowed
   function automatic logic [5:0] legal_mode(input logic [4:0] m,
                                             input logic prog,
                                             input logic exc);
      logic ok;
      logic [4:0] r;
      ok = 1'b0;
      r = m;
      if (prog) begin
         ok = (m == brf_pkg::BRF_USR) || (m == brf_pkg::BRF_FIQ) ||
              (m == brf_pkg::BRF_IRQ) || (m == brf_pkg::BRF_SVC) ||
              (m == brf_pkg::BRF_ABT) || (m == brf_pkg::BRF_UND);
      end else if (exc) begin
         // Abort and undefined have no legacy form; the os mode takes them
         r = (m[3:2] != 2'b00) ? 5'h03 : {3'h0, m[1:0]};
         ok = 1'b1;
      end else begin
         ok = (m[4:2] == 3'h0);
      end
      return {ok, r};
   endfunction

   function automatic logic [1:0] lane_of(input logic [1:0] a,
                                          input logic big);
      return big ? ~a : a;
   endfunction

   // ****************
   // State
   // ****************
   logic [31:0] gp_mem [0:brf_pkg::BRF_NGP-1];
   logic [31:0] saved_mem [0:brf_pkg::BRF_NSAVED-1];
   logic [31:0] pc_reg, pc_next;
   logic [31:0] csw_reg, csw_next;
   logic [2:0] cfg_reg, cfg_next;
   logic [31:0] reg_rdata_reg, reg_rdata_next;
   logic [31:0] rf_rdata_reg, rf_rdata_next;
   logic [28:0] mem_addr_reg, mem_addr_next;
   logic [31:0] mem_wdata_reg, mem_wdata_next;
   logic [3:0] mem_lanes_reg, mem_lanes_next;
   logic [31:0] ld_data_reg, ld_data_next;
   logic addr_exc_reg, addr_exc_next;
   logic priv_reg, priv_next;
   logic gp_we;
   brf_pkg::brf_idx_t gp_wi;
   logic [31:0] gp_wd, sv_wd;
   logic sv_we;
   logic [2:0] sv_wi;
   logic [4:0] mode;
   logic bigend, prog, data;
   logic [5:0] lm;
   logic [1:0] ln;

   assign mode = csw_reg[`BRF_MODE_HI:0];
   assign bigend = cfg_reg[`BRF_CFG_BIGEND];
   assign prog = cfg_reg[`BRF_CFG_PROG];
   assign data = cfg_reg[`BRF_CFG_DATA];

   // ****************
   // Next state
   // ****************
   always_comb begin
      cfg_next = cfg_reg;
      csw_next = csw_reg;
      pc_next = pc_reg;
      gp_we = 1'b0;
      gp_wi = bank_idx(mode, rf_waddr);
      gp_wd = rf_wdata;
      sv_we = 1'b0;
      sv_wi = saved_idx(mode);
      sv_wd = reg_wdata;
      lm = 6'h00;
      if (reg_wr && reg_addr == `BRF_CFG_OFS) begin
         cfg_next = reg_wdata[2:0];
         // Carry the running mode across a program-space change
         if (reg_wdata[`BRF_CFG_PROG] != prog) begin
            lm = legal_mode(mode, reg_wdata[`BRF_CFG_PROG], 1'b1);
            if (reg_wdata[`BRF_CFG_PROG])
               csw_next[4:0] = {1'b1, mode[3:0]};
            else
               csw_next[4:0] = lm[4:0];
         end
      end
      if (reg_wr && reg_addr == `BRF_CSW_OFS) begin
         lm = legal_mode(reg_wdata[4:0], prog, 1'b0);
         csw_next[31:5] = reg_wdata[31:5];
         if (lm[5])
            csw_next[4:0] = lm[4:0];
      end
      if (reg_wr && reg_addr == `BRF_SSW_OFS && mode[3:0] != 4'h0) begin
         sv_we = 1'b1;
      end
      if (reg_wr && reg_addr == `BRF_PC_OFS)
         pc_next = reg_wdata;
      if (rf_we && rf_waddr == 4'hF)
         pc_next = rf_wdata;
      else if (rf_we)
         gp_we = 1'b1;
      // Exception entry to an allowed mode wins over a software mode, saved-status or general-register write in the same cycle
      if (exc_req) begin
         lm = legal_mode(exc_mode, cfg_next[`BRF_CFG_PROG], 1'b1);
         if (lm[5]) begin
            csw_next[4:0] = lm[4:0];
            gp_we = 1'b1;
            gp_wi = bank_idx(lm[4:0], 4'hE);
            gp_wd = exc_link;
            sv_we = 1'b1;
            sv_wi = saved_idx(lm[4:0]);
            sv_wd = csw_reg;
         end
      end
      if (!prog)
         pc_next[31:`BRF_AWIDE_LO] = 6'h00;
      if (sys_rst) begin
         cfg_next = `BRF_CFG_RST;
         csw_next = `BRF_LEG_RST;
         pc_next = 32'h00000000;
      end
      priv_next = csw_next[3:0] != 4'h0;
   end

   always_comb begin
      reg_rdata_next = 32'h00000000;
      if (reg_rd) begin
         unique case (reg_addr)
            `BRF_CFG_OFS: reg_rdata_next = {29'h0, cfg_reg};
            `BRF_CSW_OFS: reg_rdata_next = csw_reg;
            `BRF_SSW_OFS: reg_rdata_next =
               (mode[3:0] == 4'h0) ? 32'h0 : saved_mem[saved_idx(mode)];
            `BRF_PC_OFS: reg_rdata_next = {pc_reg[31:2], 2'b00};
            default: reg_rdata_next = 32'h00000000;
         endcase
      end
      if (rf_raddr == 4'hF)
         rf_rdata_next = {pc_reg[31:2], 2'b00};
      else
         rf_rdata_next = gp_mem[bank_idx(mode, rf_raddr)];
   end

   // Memory side: only byte stores and byte loads see the byte order
   always_comb begin
      ln = lane_of(mem_vaddr[1:0], bigend);
      mem_addr_next = mem_vaddr[28:0];
      if (mem_fetch && !prog)
         mem_addr_next = {3'h0, mem_vaddr[25:2], 2'b00};
      else if (mem_fetch || !st_byte)
         mem_addr_next[1:0] = 2'b00;
      addr_exc_next = mem_req && !mem_fetch && !data &&
                      (mem_vaddr[31:`BRF_AWIDE_LO] != 6'h00);
      mem_wdata_next = st_byte ? {4{st_data[7:0]}} : st_data;
      mem_lanes_next = st_byte ? 4'h1 << ln : 4'hF;
      ld_data_next = mem_rdata;
      if (ld_byte)
         ld_data_next = {24'h0, mem_rdata[{ln, 3'b000} +: 8]};
      if (sys_rst) begin
         addr_exc_next = 1'b0;
         mem_lanes_next = 4'h0;
      end
   end

   // ****************
   // Registers
   // ****************
   always_ff @(posedge clk) begin
      cfg_reg <= cfg_next;
      csw_reg <= csw_next;
      pc_reg <= pc_next;
      reg_rdata_reg <= reg_rdata_next;
      rf_rdata_reg <= rf_rdata_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_lanes_reg <= mem_lanes_next;
      ld_data_reg <= ld_data_next;
      addr_exc_reg <= addr_exc_next;
      priv_reg <= priv_next;
      if (gp_we)
         gp_mem[gp_wi] <= gp_wd;
      if (sv_we)
         saved_mem[sv_wi] <= sv_wd;
   end

   assign mode_out = csw_reg[4:0];
   assign priv_out = priv_reg;
   assign reg_rdata = reg_rdata_reg;
   assign rf_rdata = rf_rdata_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign mem_lanes = mem_lanes_reg;
   assign ld_data = ld_data_reg;
   assign addr_exc = addr_exc_reg;

   // ****************
   // Checks
   // ****************
   property p_legacy_only;
      @(posedge clk) disable iff (sys_rst) !prog |-> mode[4] == 1'b0;
   endproperty
   a_legacy_only: assert property (p_legacy_only) else $error("wide mode");

   property p_wide_legal;
      @(posedge clk) disable iff (sys_rst)
         prog |-> mode inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B};
   endproperty
   a_wide_legal: assert property (p_wide_legal) else $error("bad mode");

   property p_pc_low;
      @(posedge clk) disable iff (sys_rst)
         rf_raddr == 4'hF |=> rf_rdata[1:0] == 2'b00 && rf_rdata[31:2] == $past(pc_reg[31:2]);
   endproperty
   a_pc_low: assert property (p_pc_low) else $error("pc read");

   property p_no_exc_wide;
      @(posedge clk) disable iff (sys_rst) data |=> !addr_exc;
   endproperty
   a_no_exc_wide: assert property (p_no_exc_wide) else $error("addr exc");

   property p_exc_narrow;
      @(posedge clk) disable iff (sys_rst)
         mem_req && !mem_fetch && !data && (mem_vaddr[31:`BRF_AWIDE_LO] != 6'h00) |=> addr_exc;
   endproperty
   a_exc_narrow: assert property (p_exc_narrow) else $error("no exc");

   property p_lane_little;
      @(posedge clk) disable iff (sys_rst)
         st_byte && !bigend && mem_vaddr[1:0] == 2'b00 |=> mem_lanes == 4'h1;
   endproperty
   a_lane_little: assert property (p_lane_little) else $error("le lane");

   property p_lane_big;
      @(posedge clk) disable iff (sys_rst)
         st_byte && bigend && mem_vaddr[1:0] == 2'b00 |=> mem_lanes == 4'h8;
   endproperty
   a_lane_big: assert property (p_lane_big) else $error("be lane");

   property p_reset_state;
      @(posedge clk) sys_rst |=> cfg_reg == 3'h0 && mode[3:0] == 4'h3;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset");

   property p_exc_priv;
      @(posedge clk) disable iff (sys_rst) exc_req |=> priv_out;
   endproperty
   a_exc_priv: assert property (p_exc_priv) else $error("exc mode");
endmodule

// [test/brf_mem_model.sv]
/*
 Memory system model on the 32-bit data bus of the banked register file.
 Assumes the bench tells it which byte order software has selected.
*/
`timescale 1ns/1ps
module brf_mem_model (
   input wire logic [28:0] mem_addr,
   input wire logic big_order,
   output logic [31:0] mem_rdata
);
   // ****************
   // Byte lanes
   // ****************
   // Byte lane j of a word holds {j, or 3-j in big order, word address bits 7:2}, so a wrong lane shows at once
   always_comb begin
      for (int j = 0; j < 4; j++) begin
         mem_rdata[8*j +: 8] = {(big_order ? 2'(3 - j) : 2'(j)), mem_addr[7:2]};
      end
   end
endmodule

// [test/brf_core_tb_top.sv]
/*
 Self-checking bench of the banked register file core.
 Assumes the memory model brf_mem_model and the package brf_pkg.
*/
`timescale 1ns/1ps
module brf_core_tb_top;
   logic clk, sys_rst, reg_wr, reg_rd, rf_we, exc_req, mem_req, mem_fetch, st_byte, ld_byte;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rf_rdata, rf_wdata, exc_link, mem_vaddr, st_data;
   logic [31:0] mem_rdata, mem_wdata, ld_data;
   logic [3:0] rf_raddr, rf_waddr, mem_lanes;
   logic [4:0] exc_mode, mode_out;
   logic [28:0] mem_addr;
   logic addr_exc, priv_out, big;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   brf_pkg::brf_mode_t modes [6] = '{brf_pkg::BRF_USR, brf_pkg::BRF_FIQ, brf_pkg::BRF_IRQ,
      brf_pkg::BRF_SVC, brf_pkg::BRF_ABT, brf_pkg::BRF_UND};

   brf_core i_brf_core (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .exc_req, .exc_mode, .exc_link,
      .mem_req, .mem_fetch, .mem_vaddr, .st_byte, .st_data, .ld_byte, .mem_rdata, .mem_addr,
      .mem_wdata, .mem_lanes, .ld_data, .addr_exc, .mode_out, .priv_out);
   brf_mem_model i_brf_mem_model (.mem_addr, .big_order(big), .mem_rdata);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Bound on the whole run; a hang lands in the same verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         results();
      end
   end

   // ****************
   // Access tasks
   // ****************
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic rfw(input logic [3:0] i, input logic [31:0] d);
      @(posedge clk);
      rf_waddr <= i;
      rf_wdata <= d;
      rf_we <= 1'b1;
      @(posedge clk);
      rf_we <= 1'b0;
   endtask
   task automatic rfchk(input logic [3:0] i, input logic [31:0] e);
      @(posedge clk);
      rf_raddr <= i;
      @(posedge clk);
      #1;
      chk("rf_rdata", rf_rdata, e);
   endtask
   task automatic setm(input logic [4:0] m);
      wr(8'h04, {27'h0, m});
   endtask
   task automatic mchk(input logic [4:0] e);
      chk("mode_out", {27'h0, mode_out}, {27'h0, e});
   endtask
   task automatic wcfg(input logic [2:0] c);
      wr(8'h00, {29'h0, c});
      big = c[0];
   endtask
   task automatic exc(input logic [4:0] m, input logic [31:0] l);
      @(posedge clk);
      exc_req <= 1'b1;
      exc_mode <= m;
      exc_link <= l;
      @(posedge clk);
      exc_req <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // Inputs are held for three cycles so the registered outputs settle
   task automatic mem(input logic [31:0] v, input logic s, input logic l, input logic f);
      @(posedge clk);
      mem_req <= 1'b1;
      mem_fetch <= f;
      mem_vaddr <= v;
      st_byte <= s;
      ld_byte <= l;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      {sys_rst, reg_wr, reg_rd, rf_we, exc_req, mem_req, mem_fetch, st_byte, ld_byte} = 9'h100;
      {reg_addr, rf_raddr, rf_waddr, exc_mode, big} = '0;
      {reg_wdata, rf_wdata, exc_link, mem_vaddr} = '0;
      st_data = 32'h0000005A;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h00000003);
      mchk(5'h03);
      wcfg(3'h6);
      for (int i = 0; i < 6; i++) begin
         setm(modes[i]);
         mchk(modes[i]);
         chk("priv_out", {31'h0, priv_out}, {31'h0, modes[i] != brf_pkg::BRF_USR});
      end
      setm(5'h14);
      mchk(brf_pkg::BRF_UND);
      setm(brf_pkg::BRF_USR);
      rfw(4'h8, 32'h8);
      rfw(4'hD, 32'hD);
      setm(brf_pkg::BRF_FIQ);
      rfw(4'h8, 32'h18);
      rfw(4'hD, 32'h1D);
      setm(brf_pkg::BRF_SVC);
      rfw(4'hD, 32'h3D);
      rfchk(4'h8, 32'h8);
      wr(8'h08, 32'hA5);
      setm(brf_pkg::BRF_FIQ);
      rfchk(4'h8, 32'h18);
      rfchk(4'hD, 32'h1D);
      wr(8'h08, 32'h5A);
      setm(brf_pkg::BRF_USR);
      rfchk(4'h8, 32'h8);
      rfchk(4'hD, 32'hD);
      setm(brf_pkg::BRF_SVC);
      rfchk(4'hD, 32'h3D);
      rdchk(8'h08, 32'hA5);
      exc(brf_pkg::BRF_IRQ, 32'h1234);
      mchk(brf_pkg::BRF_IRQ);
      rdchk(8'h08, 32'h13);
      rfchk(4'hE, 32'h1234);
      rfw(4'hF, 32'h12345677);
      rfchk(4'hF, 32'h12345674);
      rdchk(8'h0C, 32'h12345674);
      rdchk(8'h40, 32'h0);
      for (int b = 0; b < 2; b++) begin
         wcfg(3'h6 | 3'(b));
         mem(32'h000001C4, 1'b1, 1'b0, 1'b0);
         chk("mem_lanes", {28'h0, mem_lanes}, (b == 1) ? 32'h8 : 32'h1);
         mem(32'h000001C5, 1'b1, 1'b0, 1'b0);
         chk("mem_lanes", {28'h0, mem_lanes}, (b == 1) ? 32'h4 : 32'h2);
         chk("mem_wdata", mem_wdata, 32'h5A5A5A5A);
         chk("mem_addr", {3'h0, mem_addr}, 32'h1C5);
         mem(32'h000001C5, 1'b0, 1'b1, 1'b0);
         chk("ld_data", ld_data, 32'h71);
         mem(32'h000001C5, 1'b0, 1'b0, 1'b0);
         chk("mem_lanes", {28'h0, mem_lanes}, 32'hF);
         chk("ld_data", ld_data, (b == 1) ? 32'h3171B1F1 : 32'hF1B17131);
         chk("mem_addr", {3'h0, mem_addr}, 32'h1C4);
      end
      wcfg(3'h0);
      exc(brf_pkg::BRF_ABT, 32'h40);
      mchk(5'h03);
      exc(brf_pkg::BRF_IRQ, 32'h44);
      mchk(5'h02);
      setm(brf_pkg::BRF_SVC);
      mchk(5'h02);
      mem(32'h0BFFFFF6, 1'b0, 1'b0, 1'b1);
      chk("mem_addr", {3'h0, mem_addr}, 32'h03FFFFF4);
      chk("addr_exc", {31'h0, addr_exc}, 32'h0);
      mem(32'h04000000, 1'b0, 1'b1, 1'b0);
      chk("addr_exc", {31'h0, addr_exc}, 32'h1);
      wcfg(3'h4);
      @(posedge clk);
      #1;
      chk("addr_exc", {31'h0, addr_exc}, 32'h0);
      results();
   end
endmodule
